// >>> hw/dcf_channel.sv
`timescale 1ns/10ps
`default_nettype none
module dcf_channel #(
  parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear_n,
  input wire logic wr_clock,
  input wire logic wr_en_n,
  input wire logic load_n,
  input wire logic [dcf_pkg::DATA_W-1:0] din,
  input wire logic rd_clock,
  input wire logic rd_en_n,
  input wire logic q_drive_n,
  input wire logic first_dev_n,
  input wire logic rd_chain_in_n,
  input wire logic wr_chain_in_n,
  output logic [dcf_pkg::DATA_W-1:0] dout_o,
  output logic dout_oe_n,
  output logic full_n,
  output logic empty_n,
  output logic half_n,
  output logic near_full_n,
  output logic near_empty_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 2;
  localparam int SW = dcf_pkg::DATA_W + 10;
  localparam logic [dcf_pkg::THR_W-1:0] THR_DEF = dcf_pkg::thr_default(DEPTH);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DEPTH < dcf_pkg::DEPTH_MIN || DEPTH > dcf_pkg::DEPTH_MAX ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dcf_channel: DEPTH must be a power of two from 256 to 4096");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic wclk_d_q;
  logic rclk_d_q;
  logic clear_s;
  logic wclk_s;
  logic wen_s;
  logic ld_s;
  logic [dcf_pkg::DATA_W-1:0] din_s;
  logic rclk_s;
  logic ren_s;
  logic oe_s;
  logic fl_s;
  logic rxi_s;
  logic wxi_s;
  logic clr;
  logic wr_edge;
  logic rd_edge;

  // Zero reset keeps the channel in clear until pins settle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {clear_n, wr_clock, wr_en_n, load_n, din, rd_clock, rd_en_n,
                  q_drive_n, first_dev_n, rd_chain_in_n, wr_chain_in_n};
      sync2_q <= sync1_q;
    end
  end

  assign {clear_s, wclk_s, wen_s, ld_s, din_s, rclk_s, ren_s, oe_s, fl_s, rxi_s,
          wxi_s} = sync2_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wclk_d_q <= 1'b0;
      rclk_d_q <= 1'b0;
    end else begin
      wclk_d_q <= wclk_s;
      rclk_d_q <= rclk_s;
    end
  end

  // Pin clocks must run well below clk; each rise is one enable pulse
  assign clr = !clear_s;
  assign wr_edge = wclk_s & !wclk_d_q;
  assign rd_edge = rclk_s & !rclk_d_q;

  // ----------------------------------------------------------------
  // Mode capture at clear
  // ----------------------------------------------------------------
  logic mode_sa_q;
  logic fl_q;
  logic strap_sa;

  // Flags clear from the strap itself, so they agree with the new mode at once
  assign strap_sa = !rxi_s & wxi_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_sa_q <= 1'b0;
      fl_q <= 1'b0;
    end else if (clr) begin
      mode_sa_q <= strap_sa;
      fl_q <= fl_s;
    end
  end

  // ----------------------------------------------------------------
  // Queue control
  // ----------------------------------------------------------------
  logic [CW-1:0] occ_q;
  logic [CW-1:0] occ_d;
  logic [AW:0] ram_cnt_q;
  logic [AW:0] ram_cnt_d;
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic ov_q;
  logic ov_d;
  logic [1:0] age_q;
  logic full_pin_q;
  logic empty_pin_q;
  logic wr_blocked;
  logic wr_acc;
  logic stg_ready;
  logic stg_valid;
  logic [dcf_pkg::DATA_W-1:0] stg_data;
  logic ram_push;
  logic ram_has;
  logic rd_norm;
  logic sa_load;
  logic sa_drain;
  logic pop;
  logic [15:0] cap;
  logic [15:0] lvl_d;

  // Pin level means full: low in normal, high in show-ahead
  assign wr_blocked = mode_sa_q ? full_pin_q : !full_pin_q;
  assign wr_acc = wr_edge & !wen_s & ld_s & !wr_blocked & stg_ready & !clr;
  assign ram_push = stg_valid & (ram_cnt_q != (AW+1)'(DEPTH)) & !clr;
  assign ram_has = (ram_cnt_q != '0);
  assign rd_norm = rd_edge & !ren_s & ld_s & !mode_sa_q & empty_pin_q & ram_has;
  assign sa_load = rd_edge & ld_s & mode_sa_q & ram_has &
                   ((!ov_q & (age_q == dcf_pkg::SA_AGE_LOAD)) | (ov_q & !ren_s));
  assign sa_drain = rd_edge & ld_s & mode_sa_q & !ren_s & ov_q & !ram_has;
  assign pop = rd_norm | sa_load;
  assign occ_d = occ_q + CW'(wr_acc) - CW'(pop);
  assign ram_cnt_d = ram_cnt_q + (AW+1)'(ram_push) - (AW+1)'(pop);
  assign ov_d = sa_load | (ov_q & !sa_drain);
  // Output register adds one word of room in show-ahead
  assign cap = 16'(DEPTH) + 16'(mode_sa_q);
  assign lvl_d = 16'(occ_d) + 16'(ov_d);

  // Small staging buffer absorbs a write while the array is busy
  dcf_fifo #(
    .WIDTH(dcf_pkg::DATA_W),
    .DEPTH(dcf_pkg::STG_DEPTH)
  ) u_stage (
    .clk(clk),
    .arst_n(arst_n),
    .flush(clr),
    .in_valid(wr_acc),
    .in_data(din_s),
    .in_ready(stg_ready),
    .out_valid(stg_valid),
    .out_data(stg_data),
    .out_ready(ram_cnt_q != (AW+1)'(DEPTH))
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      occ_q <= '0;
      ram_cnt_q <= '0;
      wptr_q <= '0;
      rptr_q <= '0;
    end else if (clr) begin
      occ_q <= '0;
      ram_cnt_q <= '0;
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      occ_q <= occ_d;
      ram_cnt_q <= ram_cnt_d;
      if (ram_push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  // Full flag moves only on write-side edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_pin_q <= 1'b0;
    end else if (clr) begin
      full_pin_q <= !strap_sa;
    end else if (wr_edge) begin
      full_pin_q <= mode_sa_q ? (lvl_d >= cap) : (lvl_d < cap);
    end
  end

  // Empty or output-valid flag moves only on read-side edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      empty_pin_q <= 1'b0;
    end else if (clr) begin
      empty_pin_q <= strap_sa;
    end else if (rd_edge) begin
      empty_pin_q <= mode_sa_q ? !ov_d : (ram_cnt_d != '0);
    end
  end

  // Show-ahead first word waits for the third read edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ov_q <= 1'b0;
      age_q <= 2'h0;
    end else if (clr) begin
      ov_q <= 1'b0;
      age_q <= 2'h0;
    end else begin
      ov_q <= ov_d;
      if (sa_load) begin
        age_q <= 2'h0;
      end else if (rd_edge & mode_sa_q & !ov_q & ram_has &
                   (age_q != dcf_pkg::SA_AGE_LOAD)) begin
        age_q <= age_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  logic [dcf_pkg::DATA_W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (ram_push) begin
      mem_q[wptr_q] <= stg_data;
    end
  end

  // ----------------------------------------------------------------
  // Threshold registers
  // ----------------------------------------------------------------
  logic [dcf_pkg::THR_W-1:0] empty_threshold_q;
  logic [dcf_pkg::THR_W-1:0] full_threshold_q;
  dcf_pkg::dcf_thr_sel_t thr_wsel_q;
  dcf_pkg::dcf_thr_sel_t thr_rsel_q;
  logic thr_wr;
  logic thr_rd;

  assign thr_wr = wr_edge & !ld_s & !wen_s & !clr;
  // Readback refused in show-ahead mode
  assign thr_rd = rd_edge & !ld_s & !ren_s & !mode_sa_q & !clr;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      empty_threshold_q <= THR_DEF;
      full_threshold_q <= THR_DEF;
      thr_wsel_q <= dcf_pkg::dcf_thr_empty;
    end else if (clr) begin
      empty_threshold_q <= THR_DEF;
      full_threshold_q <= THR_DEF;
      thr_wsel_q <= dcf_pkg::dcf_thr_empty;
    end else if (thr_wr) begin
      case (thr_wsel_q)
        dcf_pkg::dcf_thr_empty: empty_threshold_q <= din_s[dcf_pkg::THR_W-1:0];
        dcf_pkg::dcf_thr_full: full_threshold_q <= din_s[dcf_pkg::THR_W-1:0];
        default: empty_threshold_q <= empty_threshold_q;
      endcase
      // Selector is kept when load rises again
      thr_wsel_q <= dcf_pkg::thr_next(thr_wsel_q);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_rsel_q <= dcf_pkg::dcf_thr_empty;
    end else if (clr) begin
      thr_rsel_q <= dcf_pkg::dcf_thr_empty;
    end else if (thr_rd) begin
      thr_rsel_q <= dcf_pkg::thr_next(thr_rsel_q);
    end
  end

  // ----------------------------------------------------------------
  // Output register and drive
  // ----------------------------------------------------------------
  logic [dcf_pkg::DATA_W-1:0] dout_q;
  logic oe_n_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= dcf_pkg::DOUT_RST;
    end else if (clr) begin
      dout_q <= dcf_pkg::DOUT_RST;
    end else if (pop) begin
      dout_q <= mem_q[rptr_q];
    end else if (thr_rd) begin
      dout_q <= (thr_rsel_q == dcf_pkg::dcf_thr_full) ?
                dcf_pkg::DATA_W'(full_threshold_q) :
                dcf_pkg::DATA_W'(empty_threshold_q);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_n_q <= 1'b0;
    end else begin
      oe_n_q <= oe_s;
    end
  end

  assign dout_o = dout_q;
  assign dout_oe_n = oe_n_q;
  assign full_n = full_pin_q;
  assign empty_n = empty_pin_q;

  // ----------------------------------------------------------------
  // Partial flags
  // ----------------------------------------------------------------
  logic half_q;
  logic near_full_q;
  logic near_empty_q;
  logic [15:0] lvl_now;

  // Simplified: partial flags follow the occupancy, with no skew model
  assign lvl_now = 16'(occ_q) + 16'(ov_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= 1'b1;
      near_full_q <= 1'b1;
      near_empty_q <= 1'b0;
    end else if (clr) begin
      half_q <= 1'b1;
      near_full_q <= 1'b1;
      near_empty_q <= 1'b0;
    end else begin
      half_q <= !(lvl_now > 16'(DEPTH / 2) + 16'(mode_sa_q));
      // Tied-high first-load pin makes the near-full and near-empty flags edge-timed
      if (!fl_q | wr_edge) begin
        near_full_q <= !(lvl_now + 16'(full_threshold_q) >= cap);
      end
      if (!fl_q | rd_edge) begin
        near_empty_q <= !(lvl_now <= 16'(empty_threshold_q) + 16'(mode_sa_q));
      end
    end
  end

  assign half_n = half_q;
  assign near_full_n = near_full_q;
  assign near_empty_n = near_empty_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_sa_third;
    mode_sa_q && !ov_q && (age_q == dcf_pkg::SA_AGE_LOAD) && rd_edge && ld_s && ram_has;
  endsequence

  sequence s_word_shown;
    ov_q && !empty_n;
  endsequence

  a_clear_ptrs_home: assert property (clr |=> wptr_q == '0 && rptr_q == '0)
    else $error("pointers not home after clear");
  a_clear_flag_vals: assert property (clr |=> half_n && near_full_n && !near_empty_n &&
    (empty_n == mode_sa_q) && (full_n == !mode_sa_q))
    else $error("flags wrong after clear");
  a_clear_out_thr: assert property (clr |=> dout_o == dcf_pkg::DOUT_RST &&
    empty_threshold_q == THR_DEF && full_threshold_q == THR_DEF)
    else $error("output or thresholds wrong after clear");
  a_write_counts: assert property (wr_acc && !pop |=> occ_q == $past(occ_q) + 1'b1)
    else $error("accepted write not counted");
  a_normal_cap: assert property (!mode_sa_q |-> occ_q <= CW'(DEPTH))
    else $error("normal mode overfilled");
  a_sa_cap: assert property (mode_sa_q |-> 16'(occ_q) + 16'(ov_q) <= cap)
    else $error("show-ahead overfilled");
  a_dout_holds: assert property (!clr && !pop && !thr_rd |=> $stable(dout_o))
    else $error("dout changed without a read");
  a_drive_delay: assert property (dout_oe_n == $past(q_drive_n, 3))
    else $error("drive control not three cycles behind pin");
  a_empty_blocks: assert property (!mode_sa_q && !empty_n |-> !pop)
    else $error("read taken while empty");
  a_sa_first_word: assert property (s_sa_third |=> s_word_shown)
    else $error("first show-ahead word not presented");
  a_sa_drain_flag: assert property (sa_drain |=> empty_n && !ov_q ##1 !pop [*2])
    else $error("output valid not dropped after last word");
  a_thr_idle: assert property (wr_edge && !ld_s && wen_s |=> $stable(thr_wsel_q))
    else $error("threshold selector moved without enable");
  a_thr_rotate: assert property (thr_wr |=> thr_wsel_q != $past(thr_wsel_q))
    else $error("threshold selector did not rotate");
  a_full_at_depth: assert property (wr_acc && !mode_sa_q && !ov_d && lvl_d == cap
    |=> !full_n)
    else $error("full not flagged at depth");
endmodule // dcf_channel
`default_nettype wire

// >>> hw/dcf_pkg.sv
// Operation
// - Clear sends write and read pointers home
// - Clear sets partial flags, mode-dependent full and empty
// - Clear zeroes output register, loads default thresholds
// - Enabled write edge stores din unless full
// - Normal mode full flag blocks writes, wr-edge updated
// - Show-ahead space flag blocks writes, wr-edge updated
// - Enabled read edge loads output register, else holds
// - Output drive pin gates dout buffers
// - Normal mode reads on request, empty blocks reads
// - Show-ahead first word appears on third edge
// - Show-ahead later words need request, valid drops
// - Two 12-bit thresholds, written from din, readable
// - Threshold writes rotate empty, full, empty
// - Threshold write selector survives leaving load
// - Load without write enable does nothing
// - Threshold readback uses own selector, normal only
// - Normal mode full after exactly DEPTH writes
// - Show-ahead full after DEPTH plus one writes
// - Show-ahead flag pipeline, partial flag timing choice
// - Threshold defaults 31, 63 or 127 by depth
`default_nettype none
package dcf_pkg;
  localparam int DATA_W = 18;
  localparam int THR_W = 12;
  localparam int DEPTH_MIN = 256;
  localparam int DEPTH_MID = 512;
  localparam int DEPTH_MAX = 4096;
  localparam int DEPTH_DEF = 256;
  localparam int STG_DEPTH = 4;
  localparam logic [1:0] SA_AGE_LOAD = 2'h2;
  localparam logic [DATA_W-1:0] DOUT_RST = 18'h00000;
  localparam logic [THR_W-1:0] THR_SMALL = 12'h01F;
  localparam logic [THR_W-1:0] THR_MID = 12'h03F;
  localparam logic [THR_W-1:0] THR_BIG = 12'h07F;

  typedef enum logic {dcf_thr_empty, dcf_thr_full} dcf_thr_sel_t;

  function automatic logic [THR_W-1:0] thr_default(input int depth);
    if (depth <= DEPTH_MIN) begin
      return THR_SMALL;
    end else if (depth <= DEPTH_MID) begin
      return THR_MID;
    end
    return THR_BIG;
  endfunction

  function automatic dcf_thr_sel_t thr_next(input dcf_thr_sel_t s);
    return (s == dcf_thr_empty) ? dcf_thr_full : dcf_thr_empty;
  endfunction
endpackage
`default_nettype wire

// >>> hw/dcf_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module dcf_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dcf_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Data array carries no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_stg_bounded: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("staging fifo count exceeds depth");
endmodule // dcf_fifo
`default_nettype wire

// >>> verification/dcf_partner.sv
`timescale 1ns/10ps
`default_nettype none
module dcf_partner (
  input wire logic clk,
  output logic wr_clock,
  output logic wr_en_n,
  output logic load_n,
  output logic [dcf_pkg::DATA_W-1:0] din,
  output logic rd_clock,
  output logic rd_en_n
);
  // ----
  // Writer and reader agents
  // ----
  initial begin
    wr_clock = 1'b0;
    rd_clock = 1'b0;
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    load_n = 1'b1;
    din = 18'h00000;
  end

  // Pin clocks move only inside a transfer; 4 clk per phase suits the synchronisers
  task automatic wr_cyc(input logic en_n, input logic ld_n,
                        input logic [dcf_pkg::DATA_W-1:0] d);
    @(posedge clk);
    wr_en_n <= en_n;
    load_n <= ld_n;
    din <= d;
    repeat (2) @(posedge clk);
    wr_clock <= 1'b1;
    repeat (4) @(posedge clk);
    wr_clock <= 1'b0;
    din <= ~d; // Hold time over: stale data must not look valid
    repeat (4) @(posedge clk);
  endtask

  task automatic rd_cyc(input logic en_n, input logic ld_n);
    @(posedge clk);
    rd_en_n <= en_n;
    load_n <= ld_n;
    repeat (2) @(posedge clk);
    rd_clock <= 1'b1;
    repeat (4) @(posedge clk);
    rd_clock <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // dcf_partner
`default_nettype wire

// >>> verification/dual_clock_fifo_channel_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module dual_clock_fifo_channel_control_test;
  localparam int DEPTH = 256;
  logic clk, arst_n, clear_n, q_drive_n, first_dev_n, rd_chain_in_n, wr_chain_in_n;
  logic wr_clock, wr_en_n, load_n, rd_clock, rd_en_n;
  logic [dcf_pkg::DATA_W-1:0] din, dout_o;
  logic dout_oe_n, full_n, empty_n, half_n, near_full_n, near_empty_n;
  int err_count, checks, cyc, i;

  dcf_partner p (.clk(clk), .wr_clock(wr_clock), .wr_en_n(wr_en_n), .load_n(load_n),
    .din(din), .rd_clock(rd_clock), .rd_en_n(rd_en_n));

  dcf_channel #(.DEPTH(DEPTH)) uut (.clk(clk), .arst_n(arst_n), .clear_n(clear_n),
    .wr_clock(wr_clock), .wr_en_n(wr_en_n), .load_n(load_n), .din(din),
    .rd_clock(rd_clock), .rd_en_n(rd_en_n), .q_drive_n(q_drive_n),
    .first_dev_n(first_dev_n), .rd_chain_in_n(rd_chain_in_n),
    .wr_chain_in_n(wr_chain_in_n), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .full_n(full_n), .empty_n(empty_n), .half_n(half_n),
    .near_full_n(near_full_n), .near_empty_n(near_empty_n));

  // ----
  // Clock, checking and closing
  // ----
  always #5 clk = ~clk;

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Straps are only captured while clear is held
  task automatic clear_ch(input logic sa);
    @(posedge clk);
    wr_chain_in_n <= sa;
    first_dev_n <= sa;
    rd_chain_in_n <= 1'b0;
    clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    clear_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic rd_word(input logic [17:0] exp);
    p.rd_cyc(1'b0, 1'b1);
    chk(dout_o, exp);
  endtask

  // Budget well above the roughly 9k cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      test_done;
    end
  end

  // ----
  // Test sequence
  // ----
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    clear_n = 1'b1;
    q_drive_n = 1'b0;
    first_dev_n = 1'b0;
    rd_chain_in_n = 1'b0;
    wr_chain_in_n = 1'b0;
    err_count = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    clear_ch(1'b0);
    chk(full_n, 1'b1);
    chk(empty_n, 1'b0);
    chk(half_n, 1'b1);
    chk(near_full_n, 1'b1);
    chk(near_empty_n, 1'b0);
    chk(dout_o, 18'h00000);
    chk(dout_oe_n, 1'b0);
    $display("test reset done");

    p.rd_cyc(1'b0, 1'b0);
    chk(dout_o, 18'h0001F);
    p.rd_cyc(1'b0, 1'b0);
    chk(dout_o, 18'h0001F);
    p.wr_cyc(1'b0, 1'b0, 18'h000AB);
    p.wr_cyc(1'b1, 1'b0, 18'h3FFFF);
    p.wr_cyc(1'b1, 1'b1, 18'h00000);
    p.wr_cyc(1'b0, 1'b0, 18'h000CD);
    p.wr_cyc(1'b0, 1'b0, 18'h00012);
    p.rd_cyc(1'b0, 1'b0);
    chk(dout_o, 18'h00012);
    p.rd_cyc(1'b0, 1'b0);
    chk(dout_o, 18'h000CD);
    $display("test thresholds done");

    for (i = 0; i < 3; i++) p.wr_cyc(1'b0, 1'b1, 18'h2A000 + 18'(i));
    chk(empty_n, 1'b0);
    p.rd_cyc(1'b1, 1'b1);
    chk(empty_n, 1'b1);
    chk(dout_o, 18'h000CD);
    for (i = 0; i < 3; i++) rd_word(18'h2A000 + 18'(i));
    chk(empty_n, 1'b0);
    rd_word(18'h2A002);
    $display("test data done");

    for (i = 0; i < DEPTH - 1; i++) p.wr_cyc(1'b0, 1'b1, 18'h10000 + 18'(i));
    chk(full_n, 1'b1);
    p.wr_cyc(1'b0, 1'b1, 18'h10000 + 18'(DEPTH - 1));
    chk(full_n, 1'b0);
    chk(half_n, 1'b0);
    chk(near_full_n, 1'b0);
    chk(near_empty_n, 1'b1);
    p.wr_cyc(1'b0, 1'b1, 18'h3FFFF);
    p.rd_cyc(1'b1, 1'b1);
    rd_word(18'h10000);
    chk(full_n, 1'b0);
    p.wr_cyc(1'b1, 1'b1, 18'h00000);
    chk(full_n, 1'b1);
    for (i = 1; i < DEPTH; i++) rd_word(18'h10000 + 18'(i));
    chk(empty_n, 1'b0);
    $display("test full done");

    for (i = 1; i >= 0; i--) begin
      @(posedge clk);
      q_drive_n <= i[0];
      repeat (5) @(posedge clk);
      #1;
      chk(dout_oe_n, i[0]);
    end
    $display("test drive done");

    clear_ch(1'b1);
    chk(empty_n, 1'b1);
    chk(full_n, 1'b0);
    chk(dout_o, 18'h00000);
    p.wr_cyc(1'b0, 1'b1, 18'h15555);
    repeat (2) p.rd_cyc(1'b1, 1'b1);
    chk(empty_n, 1'b1);
    p.rd_cyc(1'b1, 1'b1);
    chk(dout_o, 18'h15555);
    chk(empty_n, 1'b0);
    rd_word(18'h15555);
    chk(empty_n, 1'b1);
    rd_word(18'h15555);
    p.rd_cyc(1'b0, 1'b0);
    chk(dout_o, 18'h15555);
    p.wr_cyc(1'b0, 1'b1, 18'h20000);
    repeat (3) p.rd_cyc(1'b1, 1'b1);
    for (i = 1; i < DEPTH; i++) p.wr_cyc(1'b0, 1'b1, 18'h20000 + 18'(i));
    chk(near_empty_n, 1'b0);
    chk(full_n, 1'b0);
    p.wr_cyc(1'b0, 1'b1, 18'h20000 + 18'(DEPTH));
    chk(full_n, 1'b1);
    rd_word(18'h20001);
    chk(near_empty_n, 1'b1);
    p.wr_cyc(1'b1, 1'b1, 18'h00000);
    chk(full_n, 1'b0);
    $display("test show-ahead done");
    test_done;
  end
endmodule // dual_clock_fifo_channel_control_test
`default_nettype wire
